// ### rtl/ebc_bus_config.sv
// external bus configuration, area decode and access sequencer
`timescale 1ns/10ps

module ebc_bus_config import ebc_pkg::*; #(
	parameter int NUM_AREAS = 4
) (
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [1:0]  proc_mode_i,
	input  wire logic        width_strap_i,
	input  wire logic        width_wr_i,
	input  wire logic [3:0]  width_ctrl_i,
	input  wire logic        ctrl0_wr_i,
	input  wire logic [7:0]  ctrl0_i,
	input  wire logic        ctrl1_wr_i,
	input  wire logic [7:0]  ctrl1_i,
	input  wire logic        wait_sel_i,
	input  wire logic        dram_en_i,
	input  wire logic        acc_req_i,
	input  wire logic [23:0] acc_addr_i,
	input  wire logic        acc_write_i,
	input  wire logic [1:0]  acc_be_i,
	input  wire logic [15:0] acc_wdata_i,
	input  wire logic [15:0] data_i,
	input  wire logic [15:0] ad_i,
	output logic             acc_ready_o,
	output logic             acc_done_o,
	output logic             acc_fault_o,
	output logic [15:0]      acc_rdata_o,
	output logic [3:0]       area_width_o,
	output logic [1:0]       mux_fmt_o,
	output logic [1:0]       area_mode_o,
	output logic             port0_data_o,
	output logic             port1_data_o,
	output logic             port2_shared_o,
	output logic             port3_shared_o,
	output logic             port4_addr_o,
	output logic [3:0]       upper_sel_o,
	output logic [3:0]       upper_pin_o,
	output logic [23:0]      addr_o,
	output logic [15:0]      ad_o,
	output logic [1:0]       ad_oe_o,
	output logic [15:0]      data_o,
	output logic [1:0]       data_oe_o,
	output logic [2:0]       ale_o,
	output logic             read_n_o,
	output logic             write_n_o,
	output logic             high_byte_enable_n_o,
	output logic             dram_sel_o,
	output logic             column_strobe_low_n_o,
	output logic             column_strobe_high_n_o,
	output logic             dram_write_strobe_n_o
);

	if (NUM_AREAS != 4) begin : g_check
		$error("ebc_bus_config serves exactly four external areas");
	end

	// configuration state
	logic [3:0]  width_reg, width_next;
	logic [1:0]  mux_reg, mux_next;
	logic [1:0]  amode_reg, amode_next;
	logic [1:0]  ale_sel_reg, ale_sel_next;
	logic        init_reg, init_next;
	// access state
	ebc_state_e  state_reg, state_next;
	logic [23:0] addr_reg, addr_next;
	logic [15:0] wdata_reg, wdata_next;
	logic [15:0] rdata_reg, rdata_next;
	logic [1:0]  be_reg, be_next;
	logic [1:0]  area_reg, area_next;
	logic [1:0]  cnt_reg, cnt_next;
	logic        write_reg, write_next;
	logic        wide_reg, wide_next;
	logic        mux_acc_reg, mux_acc_next;
	logic        allmux_reg, allmux_next;
	logic        dram_reg, dram_next;
	logic        hi_reg, hi_next;
	logic        done_reg, done_next;
	logic        fault_reg, fault_next;
	// decode results
	logic        ext_mode, hit, mux_all_ok, area_mux, active;
	logic [1:0]  hit_area;
	logic [2:0]  cs_count;

	function automatic logic in_rng(input logic [23:0] a,
		input logic [23:0] lo, input logic [23:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	// bus is only driven in expansion and microprocessor modes
	assign ext_mode = (proc_mode_i != PM_SINGLE);
	// all-space multiplexing is refused in mode 0 and microprocessor mode
	assign mux_all_ok = (mux_reg == MUX_ALL) && (amode_reg != 2'h0)
		&& (proc_mode_i != PM_MICRO);

	// address to area decode for the current area mode
	always_comb begin
		hit = 1'b0;
		hit_area = 2'h0;
		case (amode_reg)
		2'h0, 2'h1: begin
			if (in_rng(acc_addr_i, ADR_AREA0_BASE, ADR_AREA0_TOP)) begin
				hit = 1'b1;
				hit_area = 2'h0;
			end else if (in_rng(acc_addr_i, ADR_AREA1_BASE,
				ADR_AREA1_TOP)) begin
				hit = 1'b1;
				hit_area = 2'h1;
			end else if (in_rng(acc_addr_i, ADR_DRAM_BASE,
				ADR_DRAM_TOP)) begin
				hit = 1'b1;
				hit_area = 2'h2;
			end else if (proc_mode_i == PM_MICRO) begin
				hit = in_rng(acc_addr_i, (amode_reg == 2'h0) ?
					ADR_AREA3_BASE : ADR_AREA3_BASE_HI, ADR_SPACE_TOP);
				hit_area = 2'h3;
			end else begin
				hit = in_rng(acc_addr_i, ADR_AREA3_BASE,
					ADR_AREA3_TOP_EXP);
				hit_area = 2'h3;
			end
		end
		2'h2: begin
			// area 1 has no range here
			if (in_rng(acc_addr_i, ADR_AREA0_BASE, ADR_AREA0_TOP)) begin
				hit = 1'b1;
				hit_area = 2'h0;
			end else if (in_rng(acc_addr_i, ADR_DRAM_BASE,
				ADR_DRAM_TOP)) begin
				hit = 1'b1;
				hit_area = 2'h2;
			end else begin
				hit = in_rng(acc_addr_i, ADR_AREA3_BASE,
					(proc_mode_i == PM_MICRO) ? ADR_SPACE_TOP :
					ADR_AREA3_TOP_EXP);
				hit_area = 2'h3;
			end
		end
		default: begin
			if (in_rng(acc_addr_i, ADR_AREA0_BASE_M3,
				ADR_AREA0_TOP)) begin
				hit = 1'b1;
				hit_area = 2'h0;
			end else if (in_rng(acc_addr_i, ADR_AREA1_BASE,
				ADR_AREA1_TOP_M3)) begin
				hit = 1'b1;
				hit_area = 2'h1;
			end else if (in_rng(acc_addr_i, ADR_AREA3_BASE,
				ADR_AREA2_TOP_M3)) begin
				hit = 1'b1;
				hit_area = 2'h2;
			end else if (proc_mode_i == PM_MICRO) begin
				hit = in_rng(acc_addr_i, ADR_AREA3_BASE_M3,
					ADR_SPACE_TOP);
				hit_area = 2'h3;
			end else begin
				hit = in_rng(acc_addr_i, ADR_AREA3_BASE_HI,
					ADR_AREA3_TOP_EXP);
				hit_area = 2'h3;
			end
		end
		endcase
	end

	// is the hit area multiplexed under the bus format field
	always_comb begin
		case (mux_reg)
		MUX_AREA0: area_mux = (amode_reg != 2'h0) && (hit_area == 2'h0);
		MUX_AREA1: area_mux = (amode_reg != 2'h0) && (amode_reg != 2'h2)
			&& (hit_area == 2'h1);
		MUX_ALL:   area_mux = mux_all_ok;
		default:   area_mux = 1'b0;
		endcase
	end

	// configuration next values
	always_comb begin
		width_next = width_reg;
		mux_next = mux_reg;
		amode_next = amode_reg;
		ale_sel_next = ale_sel_reg;
		init_next = 1'b1;
		if (!init_reg) begin
			// strap is caught at the first edge after reset release
			width_next[3] = ~width_strap_i;
		end else if (width_wr_i) begin
			width_next = width_ctrl_i;
		end
		if (ctrl0_wr_i) begin
			mux_next = ctrl0_i[MUX_FIELD_LSB +: 2];
		end
		if (ctrl1_wr_i) begin
			amode_next = ctrl1_i[AREA_MODE_LSB +: 2];
			ale_sel_next = ctrl1_i[ALE_FIELD_LSB +: 2];
		end
	end

	// configuration registers; bus format resets to separate
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			width_reg <= {1'b0, WIDTH_LOW_RST};
			mux_reg <= MUX_RST;
			amode_reg <= AREA_MODE_RST;
			ale_sel_reg <= ALE_SEL_RST;
			init_reg <= 1'b0;
		end else begin
			width_reg <= width_next;
			mux_reg <= mux_next;
			amode_reg <= amode_next;
			ale_sel_reg <= ale_sel_next;
			init_reg <= init_next;
		end
	end

	// access sequencer next values
	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		be_next = be_reg;
		area_next = area_reg;
		cnt_next = cnt_reg;
		write_next = write_reg;
		wide_next = wide_reg;
		mux_acc_next = mux_acc_reg;
		allmux_next = allmux_reg;
		dram_next = dram_reg;
		hi_next = hi_reg;
		done_next = 1'b0;
		fault_next = fault_reg;
		case (state_reg)
		ST_IDLE: begin
			if (acc_req_i && init_reg) begin
				if (!ext_mode || !hit) begin
					done_next = 1'b1;
					fault_next = 1'b1;
				end else begin
					// area picks width, format and select
					state_next = ST_ADDR;
					area_next = hit_area;
					wide_next = width_reg[hit_area];
					mux_acc_next = area_mux;
					allmux_next = mux_all_ok;
					dram_next = dram_en_i && (hit_area == 2'h2)
						&& (amode_reg != 2'h0)
						&& (amode_reg != 2'h3);
					addr_next = {acc_addr_i[23:1],
						acc_addr_i[0] | (acc_be_i == 2'h2)};
					hi_next = (acc_be_i == 2'h2);
					be_next = acc_be_i;
					write_next = acc_write_i;
					wdata_next = acc_wdata_i;
					rdata_next = 16'h0000;
					fault_next = 1'b0;
				end
			end
		end
		ST_ADDR: begin
			cnt_next = mux_acc_reg ? MUX_WAITS :
				{1'b0, wait_sel_i};
			state_next = (mux_acc_reg || wait_sel_i) ? ST_WAIT : ST_DATA;
		end
		ST_WAIT: begin
			cnt_next = cnt_reg - 2'h1;
			if (cnt_reg == 2'h1) begin
				state_next = ST_DATA;
			end
		end
		ST_DATA: begin
			// 16-bit internal word built from one or two bus cycles
			if (wide_reg) begin
				rdata_next = mux_acc_reg ? ad_i : data_i;
			end else if (hi_reg) begin
				rdata_next[15:8] = mux_acc_reg ? ad_i[7:0] : data_i[7:0];
			end else begin
				rdata_next[7:0] = mux_acc_reg ? ad_i[7:0] : data_i[7:0];
			end
			if (!wide_reg && !hi_reg && be_reg[1]) begin
				state_next = ST_ADDR;
				hi_next = 1'b1;
				addr_next = {addr_reg[23:1], 1'b1};
			end else begin
				state_next = ST_IDLE;
				done_next = 1'b1;
			end
		end
		default: state_next = ST_IDLE;
		endcase
	end

	// access sequencer registers
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= ST_IDLE;
			addr_reg <= 24'h000000;
			wdata_reg <= 16'h0000;
			rdata_reg <= 16'h0000;
			be_reg <= 2'h0;
			area_reg <= 2'h0;
			cnt_reg <= 2'h0;
			write_reg <= 1'b0;
			wide_reg <= 1'b0;
			mux_acc_reg <= 1'b0;
			allmux_reg <= 1'b0;
			dram_reg <= 1'b0;
			hi_reg <= 1'b0;
			done_reg <= 1'b0;
			fault_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			be_reg <= be_next;
			area_reg <= area_next;
			cnt_reg <= cnt_next;
			write_reg <= write_next;
			wide_reg <= wide_next;
			mux_acc_reg <= mux_acc_next;
			allmux_reg <= allmux_next;
			dram_reg <= dram_next;
			hi_reg <= hi_next;
			done_reg <= done_next;
			fault_reg <= fault_next;
		end
	end

	assign active = (state_reg != ST_IDLE);
	assign acc_ready_o = (state_reg == ST_IDLE) && init_reg;
	assign acc_done_o = done_reg;
	assign acc_fault_o = fault_reg;
	assign acc_rdata_o = rdata_reg;
	assign area_width_o = width_reg;
	assign mux_fmt_o = mux_reg;
	assign area_mode_o = amode_reg;

	// pin roles from the current configuration
	assign port0_data_o = ext_mode && !mux_all_ok;
	assign port1_data_o = ext_mode && !mux_all_ok && (|width_reg);
	assign port2_shared_o = ext_mode && (mux_reg != MUX_SEPARATE)
		&& (amode_reg != 2'h0);
	assign port3_shared_o = port2_shared_o && (|width_reg);
	assign port4_addr_o = ext_mode && !mux_all_ok;
	assign cs_count = (amode_reg == 2'h1) ? 3'h3 :
		(amode_reg == 2'h2) ? 3'h2 : (amode_reg == 2'h3) ? 3'h4 : 3'h0;

	// upper pins: pin k selects area (k+3)%4 or carries address 23-k, inverted on pin 0
	for (genvar k = 0; k < NUM_AREAS; k++) begin : g_upper
		localparam logic [1:0] PIN_AREA = 2'((k + 3) % 4);
		always_comb begin
			upper_sel_o[k] = ext_mode && (3'(k) < cs_count);
			if (upper_sel_o[k]) begin
				upper_pin_o[k] = !(active && area_reg == PIN_AREA);
			end else if (k == 0) begin
				upper_pin_o[k] = !addr_o[23];
			end else begin
				upper_pin_o[k] = addr_o[23 - k];
			end
		end
	end

	// full-space multiplexing drives only the low sixteen address lines
	assign addr_o = allmux_reg ? {8'h00, addr_reg[15:0]} :
		addr_reg;

	// address/data pins: low lane always shared when multiplexed
	always_comb begin
		ad_o = addr_reg[15:0];
		ad_oe_o = {2{active}};
		if (active && mux_acc_reg && state_reg != ST_ADDR) begin
			ad_o[7:0] = hi_reg ? wdata_reg[15:8] : wdata_reg[7:0];
			ad_oe_o[0] = write_reg;
			if (wide_reg) begin
				ad_o = wdata_reg;
				ad_oe_o[1] = write_reg;
			end
		end
	end

	// separate data pins; the high lane floats for 8-bit areas
	always_comb begin
		data_o = wdata_reg;
		if (!wide_reg && hi_reg) begin
			data_o[7:0] = wdata_reg[15:8];
		end
		data_oe_o[0] = active && write_reg && !mux_acc_reg;
		data_oe_o[1] = data_oe_o[0] && wide_reg;
	end

	// latch enable pulses on the chosen pin in the address phase of multiplexed accesses
	always_comb begin
		ale_o = 3'h0;
		if (ale_sel_reg != 2'h0 && state_reg == ST_ADDR && mux_acc_reg) begin
			ale_o[ale_sel_reg - 2'h1] = 1'b1;
		end
	end

	// strobes; dram accesses swap to column strobes
	assign dram_sel_o = active && dram_reg;
	assign read_n_o = !(state_reg == ST_DATA && !write_reg && !dram_reg);
	assign write_n_o = !(state_reg == ST_DATA && write_reg && !dram_reg);
	assign high_byte_enable_n_o = !(active && wide_reg && be_reg[1]
		&& !dram_reg);
	assign column_strobe_low_n_o = !(state_reg == ST_DATA && dram_reg
		&& be_reg[0]);
	assign column_strobe_high_n_o = !(state_reg == ST_DATA && dram_reg
		&& be_reg[1]);
	assign dram_write_strobe_n_o = !(dram_sel_o && write_reg);

	// checks
	AST_WIDTH_TAKEN: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(state_reg == ST_IDLE && state_next == ST_ADDR && !width_wr_i)
		|=> (wide_reg == width_reg[area_reg]))
		else $error("access width differs from its area setting");
	AST_STRAP_WIDTH: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		$rose(init_reg) |-> (width_reg[3] == !$past(width_strap_i)))
		else $error("area 3 width does not follow the strap");
	AST_MUX_TWO_WAITS: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(state_reg == ST_ADDR && mux_acc_reg) |=> (state_reg == ST_WAIT)
		##1 (state_reg == ST_WAIT) ##1 (state_reg == ST_DATA))
		else $error("multiplexed access without two waits");
	AST_SEP_NO_WAIT: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(state_reg == ST_ADDR && !mux_acc_reg && !wait_sel_i)
		|=> (state_reg == ST_DATA))
		else $error("separate access took a wait not selected");
	AST_NO_ALLMUX_MICRO: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(proc_mode_i == PM_MICRO && state_reg == ST_ADDR) |-> !allmux_reg)
		else $error("full space multiplexing in microprocessor mode");
	AST_MODE2_AREA1: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(amode_reg == 2'h2) |-> (!upper_sel_o[2] && !(active
		&& area_reg == 2'h1 && $past(state_reg) == ST_IDLE)))
		else $error("area 1 used in area mode 2");
	AST_PORT1_IO: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(width_reg == 4'h0) |-> (!port1_data_o && !data_oe_o[1]))
		else $error("port 1 used as data with all areas 8-bit");
	AST_SINGLE_FAULT: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(acc_ready_o && acc_req_i && proc_mode_i == PM_SINGLE)
		|=> (acc_done_o && acc_fault_o && state_reg == ST_IDLE))
		else $error("external access ran in single-chip mode");
	AST_ALLMUX_ADDR: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(active && allmux_reg) |-> (addr_o[23:16] == 8'h00))
		else $error("upper address driven under full space multiplexing");
	AST_DRAM_STROBES: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(state_reg == ST_DATA && dram_reg) |-> (read_n_o && write_n_o
		&& (column_strobe_low_n_o != be_reg[0])))
		else $error("dram access used plain strobes");
	COV_MUX_ACCESS: cover property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(state_reg == ST_DATA && mux_acc_reg) ##1 acc_done_o);
	COV_NARROW_WORD: cover property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		(state_reg == ST_DATA && !hi_reg) ##1 (state_reg == ST_ADDR));
	COV_DRAM_WRITE: cover property (@(posedge core_clk_i)
		disable iff (!reset_n_i) !dram_write_strobe_n_o);
	COV_FAULT: cover property (@(posedge core_clk_i)
		disable iff (!reset_n_i) acc_done_o && acc_fault_o);

endmodule

// ### rtl/ebc_pkg.sv
// constants, field layouts and types of the external bus configuration block
package ebc_pkg;

	// processor mode codes (processor mode bits 1:0)
	localparam logic [1:0] PM_SINGLE = 2'h0;
	localparam logic [1:0] PM_EXPAND = 2'h1;
	localparam logic [1:0] PM_MICRO  = 2'h3;

	// first mode control byte: bus format field
	localparam int         MUX_FIELD_LSB = 4;
	localparam logic [1:0] MUX_SEPARATE  = 2'h0;
	localparam logic [1:0] MUX_AREA0     = 2'h1;
	localparam logic [1:0] MUX_AREA1     = 2'h2;
	localparam logic [1:0] MUX_ALL       = 2'h3;
	localparam logic [1:0] MUX_RST       = MUX_SEPARATE;

	// second mode control byte: area mode and latch-enable pin fields
	localparam int         AREA_MODE_LSB = 0;
	localparam int         ALE_FIELD_LSB = 4;
	localparam logic [1:0] AREA_MODE_RST = 2'h0;
	localparam logic [1:0] ALE_SEL_RST   = 2'h0;

	// width control reset for areas 0 to 2 (area 3 follows the strap)
	localparam logic [2:0] WIDTH_LOW_RST = 3'h0;

	// waits forced on every multiplexed access
	localparam logic [1:0] MUX_WAITS = 2'h2;

	// area boundaries
	localparam logic [23:0] ADR_AREA0_BASE    = 24'h008000;
	localparam logic [23:0] ADR_AREA0_BASE_M3 = 24'h100000;
	localparam logic [23:0] ADR_AREA0_TOP     = 24'h1FFFFF;
	localparam logic [23:0] ADR_AREA1_BASE    = 24'h200000;
	localparam logic [23:0] ADR_AREA1_TOP_M3  = 24'h2FFFFF;
	localparam logic [23:0] ADR_AREA1_TOP     = 24'h3FFFFF;
	localparam logic [23:0] ADR_DRAM_BASE     = 24'h400000;
	localparam logic [23:0] ADR_DRAM_TOP      = 24'hBFFFFF;
	localparam logic [23:0] ADR_AREA3_BASE    = 24'hC00000;
	localparam logic [23:0] ADR_AREA2_TOP_M3  = 24'hCFFFFF;
	localparam logic [23:0] ADR_AREA3_BASE_HI = 24'hE00000;
	localparam logic [23:0] ADR_AREA3_TOP_EXP = 24'hEFFFFF;
	localparam logic [23:0] ADR_AREA3_BASE_M3 = 24'hF00000;
	localparam logic [23:0] ADR_SPACE_TOP     = 24'hFFFFFF;

	// access sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ADDR,
		ST_WAIT,
		ST_DATA
	} ebc_state_e;

endpackage

// ### tb/ebc_mem_model.sv
// behavioural external memory on the separate and shared data pins
`timescale 1ns/10ps

module ebc_mem_model (
	input  wire logic        core_clk_i,
	input  wire logic [23:0] addr_i,
	input  wire logic        read_n_i,
	input  wire logic        write_n_i,
	input  wire logic [1:0]  data_oe_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic [15:0] ad_i,
	output logic      [15:0] data_o,
	output logic      [15:0] ad_o
);
	logic [15:0] mem [0:127];
	logic [15:0] rd_word, rd_lane;

	// preload a known pattern so reads never see unknowns
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 16'h1000 + 16'(i);
		end
	end

	// word addressed by bits 7:1 of the bus address
	assign rd_word = mem[addr_i[7:1]];

	// an odd address puts the high byte on the low lane for 8-bit areas
	assign rd_lane = {rd_word[15:8],
		addr_i[0] ? rd_word[15:8] : rd_word[7:0]};

	// outside a read strobe the pins float, shown as the inverted word
	assign data_o = !read_n_i ? rd_lane : ~rd_lane;
	assign ad_o   = !read_n_i ? rd_lane : ~rd_lane;

	// write strobe stores from whichever pin group is being driven
	always @(posedge core_clk_i) begin
		if (!write_n_i) begin
			mem[addr_i[7:1]] <= (data_oe_i != 2'h0) ? wdata_i : ad_i;
		end
	end
endmodule

// ### tb/external_bus_configuration_tb.sv
// self-checking bench for the external bus configuration block
`timescale 1ns/10ps

module external_bus_configuration_tb import ebc_pkg::*;;
	logic        core_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [1:0]  proc_mode_i = PM_EXPAND;
	logic        width_wr_i = 1'b0;
	logic [3:0]  width_ctrl_i = 4'h0;
	logic        ctrl0_wr_i = 1'b0;
	logic [7:0]  ctrl0_i = 8'h00;
	logic        ctrl1_wr_i = 1'b0;
	logic [7:0]  ctrl1_i = 8'h00;
	logic        wait_sel_i = 1'b0;
	logic        acc_req_i = 1'b0;
	logic [23:0] acc_addr_i = 24'h000000;
	logic        acc_write_i = 1'b0;
	logic [15:0] acc_wdata_i = 16'h0000;
	logic [15:0] data_i, ad_i, acc_rdata_o, ad_o, data_o;
	logic        acc_ready_o, acc_done_o, acc_fault_o, read_n_o, write_n_o;
	logic        port0_data_o, port1_data_o;
	logic [3:0]  area_width_o;
	logic [1:0]  mux_fmt_o, area_mode_o, ad_oe_o, data_oe_o;
	logic [23:0] addr_o;
	logic        width_strap_i = 1'b0;
	logic        dram_en_i = 1'b0;
	logic [3:0]  upper_sel_o, upper_pin_o, sel_seen;
	logic [2:0]  ale_o, ale_seen;
	logic        column_strobe_low_n_o, cas_seen;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          n;
	logic [15:0] rdat;

	// 20 MHz clock
	initial begin
		forever #25 core_clk_i = ~core_clk_i;
	end

	ebc_bus_config dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.proc_mode_i(proc_mode_i), .width_strap_i(width_strap_i),
		.width_wr_i(width_wr_i), .width_ctrl_i(width_ctrl_i),
		.ctrl0_wr_i(ctrl0_wr_i), .ctrl0_i(ctrl0_i), .ctrl1_wr_i(ctrl1_wr_i),
		.ctrl1_i(ctrl1_i), .wait_sel_i(wait_sel_i), .dram_en_i(dram_en_i),
		.acc_req_i(acc_req_i), .acc_addr_i(acc_addr_i),
		.acc_write_i(acc_write_i), .acc_be_i(2'h3),
		.acc_wdata_i(acc_wdata_i), .data_i(data_i), .ad_i(ad_i),
		.acc_ready_o(acc_ready_o), .acc_done_o(acc_done_o),
		.acc_fault_o(acc_fault_o), .acc_rdata_o(acc_rdata_o),
		.area_width_o(area_width_o), .mux_fmt_o(mux_fmt_o),
		.area_mode_o(area_mode_o), .port0_data_o(port0_data_o),
		.port1_data_o(port1_data_o), .port2_shared_o(), .port3_shared_o(),
		.port4_addr_o(), .upper_sel_o(upper_sel_o),
		.upper_pin_o(upper_pin_o), .addr_o(addr_o),
		.ad_o(ad_o), .ad_oe_o(ad_oe_o), .data_o(data_o),
		.data_oe_o(data_oe_o), .ale_o(ale_o), .read_n_o(read_n_o),
		.write_n_o(write_n_o), .high_byte_enable_n_o(),
		.dram_sel_o(), .column_strobe_low_n_o(column_strobe_low_n_o),
		.column_strobe_high_n_o(), .dram_write_strobe_n_o());

	ebc_mem_model mem (.core_clk_i(core_clk_i), .addr_i(addr_o),
		.read_n_i(read_n_o), .write_n_i(write_n_o), .data_oe_i(data_oe_o),
		.wdata_i(data_o), .ad_i(ad_o), .data_o(data_i), .ad_o(ad_i));

	// verdict and end of run
	task automatic finish_test();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// compare a design value
	task automatic chk_v(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// compare a cycle count
	task automatic chk_n(input int got, input int exp);
		num_checks++;
		if (got != exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// write both mode control bytes and the width byte
	task automatic cfg(input logic [1:0] fmt, input logic [1:0] amode,
		input logic [3:0] wid);
		@(posedge core_clk_i);
		ctrl0_i    <= {2'h0, fmt, 4'h0};
		ctrl0_wr_i <= 1'b1;
		ctrl1_i    <= {4'h1, 2'h0, amode}; // latch enable on pin 0
		ctrl1_wr_i <= 1'b1;
		width_ctrl_i <= wid;
		width_wr_i <= 1'b1;
		@(posedge core_clk_i);
		ctrl0_wr_i <= 1'b0;
		ctrl1_wr_i <= 1'b0;
		width_wr_i <= 1'b0;
		@(negedge core_clk_i);
	endtask

	// one access: hold request until taken, count edges until done
	task automatic access(input logic [23:0] a, input logic wr,
		input logic [15:0] wd, output int cnt, output logic [15:0] rd);
		@(posedge core_clk_i);
		acc_req_i   <= 1'b1;
		acc_addr_i  <= a;
		acc_write_i <= wr;
		acc_wdata_i <= wd;
		@(negedge core_clk_i);
		for (int i = 0; i < 20 && acc_ready_o !== 1'b1; i++) begin
			@(negedge core_clk_i);
		end
		@(posedge core_clk_i);
		acc_req_i <= 1'b0;
		cnt = 1;
		@(negedge core_clk_i);
		while (acc_done_o !== 1'b1 && cnt < 20) begin
			cnt++;
			@(negedge core_clk_i);
		end
		rd = acc_rdata_o;
	endtask

	// hang guard
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			n_mismatch++;
			finish_test();
		end
	end

	// collect latch-enable, select and column-strobe activity per access
	always @(negedge core_clk_i) begin
		if (acc_req_i && acc_ready_o) begin
			ale_seen <= 3'h0;
			sel_seen <= 4'h0;
			cas_seen <= 1'b0;
		end else begin
			ale_seen <= ale_seen | ale_o;
			sel_seen <= sel_seen | (upper_sel_o & ~upper_pin_o);
			cas_seen <= cas_seen | !column_strobe_low_n_o;
		end
	end

	initial begin
		repeat (2) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(negedge core_clk_i);
		chk_v(24'(area_width_o), 24'h000008);
		chk_v(24'(mux_fmt_o), 24'(MUX_SEPARATE));
		cfg(MUX_SEPARATE, 2'h1, 4'h0);
		chk_v(24'(area_width_o), 24'h000000);
		chk_v(24'(area_mode_o), 24'h000001);
		chk_v({22'h0, port1_data_o, port0_data_o}, 24'h000001);
		cfg(MUX_SEPARATE, 2'h1, 4'h5);
		chk_v(24'(area_width_o), 24'h000005);
		chk_v({22'h0, port1_data_o, port0_data_o}, 24'h000003);
		// separate write then read back, no wait and one wait
		access(24'h010004, 1'b1, 16'hA55A, n, rdat);
		chk_n(n, 3);
		chk_v(24'(sel_seen), 24'h000002);
		access(24'h010004, 1'b0, 16'h0000, n, rdat);
		chk_v(24'(rdat), 24'h00A55A);
		@(posedge core_clk_i) wait_sel_i <= 1'b1;
		access(24'h010006, 1'b0, 16'h0000, n, rdat);
		chk_n(n, 4);
		chk_v(24'(rdat), 24'h001003);
		chk_v(24'(upper_sel_o), 24'h000007);
		// multiplexed area 0 takes two forced waits either way
		cfg(MUX_AREA0, 2'h1, 4'h5);
		chk_v(24'(mux_fmt_o), 24'(MUX_AREA0));
		for (int w = 0; w < 2; w++) begin
			@(posedge core_clk_i) wait_sel_i <= w[0];
			access(24'h010004, 1'b0, 16'h0000, n, rdat);
			chk_n(n, 5);
			chk_v(24'(rdat), 24'h00A55A);
		end
		// 8-bit multiplexed area: two byte cycles on the low lane
		cfg(MUX_AREA0, 2'h1, 4'h4);
		access(24'h010004, 1'b0, 16'h0000, n, rdat);
		chk_n(n, 9);
		chk_v(24'(rdat), 24'h00A55A);
		chk_v(24'(ale_seen), 24'h000001);
		// full-space multiplexing is refused in microprocessor mode
		@(posedge core_clk_i) proc_mode_i <= PM_MICRO;
		cfg(MUX_ALL, 2'h1, 4'h5);
		access(24'h010008, 1'b0, 16'h0000, n, rdat);
		chk_n(n, 4);
		@(posedge core_clk_i) proc_mode_i <= PM_EXPAND;
		access(24'h010008, 1'b0, 16'h0000, n, rdat);
		chk_n(n, 5);
		chk_v(24'(rdat), 24'h001004);
		// area 1 is not decoded in mode 2
		cfg(MUX_SEPARATE, 2'h2, 4'h5);
		chk_v(24'(upper_sel_o), 24'h000003);
		access(24'h200000, 1'b0, 16'h0000, n, rdat);
		chk_v(24'(acc_fault_o), 24'h000001);
		access(24'h010004, 1'b0, 16'h0000, n, rdat);
		chk_v(24'(acc_fault_o), 24'h000000);
		// dram region in mode 2 swaps to the column strobes
		@(posedge core_clk_i) dram_en_i <= 1'b1;
		access(24'h400004, 1'b1, 16'h1234, n, rdat);
		chk_v(24'(acc_fault_o), 24'h000000);
		chk_v(24'(cas_seen), 24'h000001);
		// single-chip mode keeps the bus idle
		@(posedge core_clk_i) proc_mode_i <= PM_SINGLE;
		access(24'h010004, 1'b0, 16'h0000, n, rdat);
		chk_v(24'(acc_fault_o), 24'h000001);
		chk_v(24'(port0_data_o), 24'h000000);
		// strap high across a second reset: area 3 comes up 8-bit
		@(posedge core_clk_i) reset_n_i <= 1'b0;
		width_strap_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(negedge core_clk_i);
		chk_v(24'(area_width_o), 24'h000000);
		chk_v(24'(mux_fmt_o), 24'(MUX_SEPARATE));
		finish_test();
	end
endmodule
